/* design/esm_top.v */
// Encoder speed measurement with an AXI4-Lite register slave
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "esm_map.vh"
// Notes on behaviour
// - Encoder inputs handle pulses up to 50 kHz
// - Measure only while encoder enable is set
// - Pulses per revolution divides the frequency
// - Single or double channel encoder selectable
// - Multiply factor scales pulses for gearbox mounting
// - Count pulses over a programmable sampling period
// - Double channel counts four edges per pulse
// - Frequency equals count, divided by four in double channel, times poles over product
// - Last period count is readable
module esm_top (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Encoder pins
    input  wire        enc_a,
    input  wire        enc_b
);
    localparam DW = 48;

    // Settings
    reg        en_q;
    reg        dual_q;
    reg [15:0] ppr_q;
    reg [15:0] mult_q;
    reg [7:0]  poles_q;
    reg [31:0] period_q;
    // Measurement state
    reg [31:0] tick_q;
    reg [15:0] acc_q;
    reg [15:0] cnt_q;
    reg        ovf_q;
    reg        valid_q;
    reg [31:0] freq_q;

    // Input synchronisers, then an edge history stage
    reg [1:0] sa_q;
    reg [1:0] sb_q;
    reg       pa_q;
    reg       pb_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            sa_q <= 2'b00;
            sb_q <= 2'b00;
            pa_q <= 1'b0;
            pb_q <= 1'b0;
        end else begin
            sa_q <= {sa_q[0], enc_a};
            sb_q <= {sb_q[0], enc_b};
            pa_q <= sa_q[1];
            pb_q <= sb_q[1];
        end
    end
    // 25 MHz sampling resolves 50 kHz edges with wide margin
    wire a_rise = sa_q[1] & ~pa_q;
    wire a_edge = sa_q[1] ^ pa_q;
    wire b_edge = sb_q[1] ^ pb_q;
    wire step   = dual_q ? (a_edge | b_edge) : a_rise;

    // Period end and accumulation
    wire period_end = en_q && (tick_q + 32'h0000_0001 >= period_q);
    wire [15:0] acc_inc = acc_q + {15'h0000, step};
    wire        sat     = (acc_q == `ESM_CNT_MAX) && step;

    always @(posedge aclk) begin
        if (!aresetn || !en_q) begin
            tick_q  <= 32'h0000_0000;
            acc_q   <= 16'h0000;
        end else if (period_end) begin
            tick_q <= 32'h0000_0000;
            acc_q  <= {15'h0000, step};
        end else begin
            tick_q <= tick_q + 32'h0000_0001;
            if (!sat)
                acc_q <= acc_inc;
        end
    end

    // Divider request: count * poles * 2^F / (ppr * mult * T)
    wire [DW-1:0] num_w = ({{(DW-16){1'b0}}, cnt_q}
                          * {{(DW-8){1'b0}}, poles_q})
                          << `ESM_FRAC_BITS;
    localparam [31:0] CLK_HZ = `ESM_CLK_HZ;
    wire [DW-1:0] clk_w = {{(DW-32){1'b0}}, CLK_HZ};
    wire [DW-1:0] dvs_w = ({{(DW-16){1'b0}}, ppr_q}
                          * {{(DW-16){1'b0}}, mult_q}
                          * {{(DW-32){1'b0}}, period_q});
    reg           div_go_q;
    wire          div_done;
    wire [DW-1:0] div_q;
    // Time is period_q/clk, so multiply numerator by clock rate
    wire [DW-1:0] num_s = dual_q ? (num_w >> `ESM_QUAD_FACT) : num_w;
    esm_divider #(.W(DW)) u_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .start    (div_go_q),
        .dividend (num_s * clk_w),
        .divisor  (dvs_w),
        .done     (div_done),
        .quotient (div_q)
    );

    always @(posedge aclk) begin
        if (!aresetn || !en_q) begin
            cnt_q    <= 16'h0000;
            ovf_q    <= 1'b0;
            valid_q  <= 1'b0;
            div_go_q <= 1'b0;
            freq_q   <= 32'h0000_0000;
        end else begin
            div_go_q <= period_end;
            if (period_end) begin
                cnt_q <= acc_q;
                ovf_q <= ovf_q | sat;
            end else if (sat) begin
                ovf_q <= 1'b1;
            end
            if (div_done) begin
                freq_q  <= div_q[31:0];
                valid_q <= 1'b1;
            end
        end
    end

    // AXI4-Lite write channel
    reg       aw_q;
    reg       w_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_q && !s_axi_bvalid;
    wire do_wr = aw_q && w_q && !s_axi_bvalid;
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  st;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
                merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction
    wire [31:0] ctrl_old = {30'h0000_0000, dual_q, en_q};
    wire [31:0] ctrl_new = merge(ctrl_old, wdata_q, wstrb_q);
    wire [31:0] ppr_new  = merge({16'h0000, ppr_q}, wdata_q, wstrb_q);
    wire [31:0] mult_new = merge({16'h0000, mult_q}, wdata_q, wstrb_q);
    wire [31:0] per_new  = merge(period_q, wdata_q, wstrb_q);
    wire [31:0] pol_new  = merge({24'h00_0000, poles_q}, wdata_q, wstrb_q);
    reg         wr_hit;
    always @* begin
        case (awaddr_q)
            `ESM_OFF_CTRL, `ESM_OFF_PPR, `ESM_OFF_MULT,
            `ESM_OFF_PERIOD, `ESM_OFF_POLES: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            awaddr_q     <= 8'h00;
            wdata_q      <= 32'h0000_0000;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ESM_RESP_OKAY;
            en_q         <= 1'b0;
            dual_q       <= 1'b0;
            ppr_q        <= `ESM_PPR_RST;
            mult_q       <= `ESM_MULT_RST;
            period_q     <= `ESM_PERIOD_RST;
            poles_q      <= `ESM_POLES_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q     <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_q         <= 1'b0;
                w_q          <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `ESM_RESP_OKAY : `ESM_RESP_SLVERR;
                case (awaddr_q)
                    `ESM_OFF_CTRL: begin
                        en_q   <= ctrl_new[`ESM_CTRL_EN];
                        dual_q <= ctrl_new[`ESM_CTRL_DUAL];
                    end
                    `ESM_OFF_PPR:    ppr_q    <= ppr_new[15:0];
                    `ESM_OFF_MULT:   mult_q   <= mult_new[15:0];
                    `ESM_OFF_PERIOD: period_q <= per_new;
                    `ESM_OFF_POLES:  poles_q  <= pol_new[7:0];
                    default: ;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel
    assign s_axi_arready = !s_axi_rvalid;
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `ESM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `ESM_RESP_OKAY;
            case (s_axi_araddr)
                `ESM_OFF_CTRL:   s_axi_rdata <= ctrl_old;
                `ESM_OFF_PPR:    s_axi_rdata <= {16'h0000, ppr_q};
                `ESM_OFF_MULT:   s_axi_rdata <= {16'h0000, mult_q};
                `ESM_OFF_PERIOD: s_axi_rdata <= period_q;
                `ESM_OFF_COUNT:  s_axi_rdata <= {16'h0000, cnt_q};
                `ESM_OFF_FREQ:   s_axi_rdata <= freq_q;
                `ESM_OFF_STATUS: s_axi_rdata <= {30'h0000_0000, ovf_q,
                                                 valid_q};
                `ESM_OFF_POLES:  s_axi_rdata <= {24'h00_0000, poles_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `ESM_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* design/esm_map.vh */
// Register map and constants for the encoder speed measurement block
`ifndef ESM_MAP_VH
`define ESM_MAP_VH
`define ESM_OFF_CTRL      8'h00
`define ESM_OFF_PPR       8'h04
`define ESM_OFF_MULT      8'h08
`define ESM_OFF_PERIOD    8'h0C
`define ESM_OFF_COUNT     8'h10
`define ESM_OFF_FREQ      8'h14
`define ESM_OFF_STATUS    8'h18
`define ESM_OFF_POLES     8'h1C
`define ESM_CTRL_EN       0
`define ESM_CTRL_DUAL     1
`define ESM_PPR_RST       16'h0400
`define ESM_MULT_RST      16'h0001
`define ESM_POLES_RST     8'h02
`define ESM_PERIOD_RST    32'h0000_61A8
`define ESM_CNT_MAX       16'h7FFF
`define ESM_QUAD_FACT     2
`define ESM_CLK_HZ        25000000
`define ESM_MAX_PULSE_HZ  50000
`define ESM_FRAC_BITS     8
`define ESM_RESP_OKAY     2'b00
`define ESM_RESP_SLVERR   2'b10
`endif

/* design/esm_divider.v */
// Sequential unsigned divider used for the frequency result
`timescale 1ns/1ns
module esm_divider #(
    parameter W = 48
) (
    // Clock and reset
    input  wire         aclk,
    input  wire         aresetn,
    // Request
    input  wire         start,
    input  wire [W-1:0] dividend,
    input  wire [W-1:0] divisor,
    // Result
    output reg          done,
    output reg  [W-1:0] quotient
);
    // Step count register is 8 bits, so W must stay below 256
    localparam [7:0] STEPS = W;
    reg [W-1:0] rem_q;
    reg [W-1:0] quo_q;
    reg [W-1:0] dvs_q;
    reg [7:0]   cnt_q;
    reg         busy_q;
    wire [W:0]  trial = {rem_q, quo_q[W-1]};
    wire        fits  = trial >= {1'b0, dvs_q};

    always @(posedge aclk) begin
        if (!aresetn) begin
            rem_q    <= {W{1'b0}};
            quo_q    <= {W{1'b0}};
            dvs_q    <= {W{1'b0}};
            cnt_q    <= 8'h00;
            busy_q   <= 1'b0;
            done     <= 1'b0;
            quotient <= {W{1'b0}};
        end else begin
            done <= 1'b0;
            if (start && !busy_q) begin
                rem_q  <= {W{1'b0}};
                quo_q  <= dividend;
                dvs_q  <= divisor;
                cnt_q  <= STEPS;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (fits)
                    rem_q <= trial[W-1:0] - dvs_q;
                else
                    rem_q <= trial[W-1:0];
                quo_q <= {quo_q[W-2:0], fits};
                cnt_q <= cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    busy_q <= 1'b0;
                    done   <= 1'b1;
                    // Zero divisor gives all ones, a visible saturation
                    quotient <= {quo_q[W-2:0], fits};
                end
            end
        end
    end
endmodule

/* sim/esm_enc_model.sv */
// Incremental encoder model with single or quadrature output
`timescale 1ns/1ns
module esm_enc_model #(
    parameter Q = 125
) (
    // Clock and control
    input  wire aclk,
    input  wire run,
    input  wire dual,
    // Encoder pins
    output reg  enc_a = 1'b0,
    output reg  enc_b = 1'b0
);
    integer cnt = 0;
    // Four steps of Q cycles per pulse hold the rate at 50 kHz
    always @(posedge aclk) begin
        if (run) begin
            cnt = (cnt + 1) % (4 * Q);
        end
        enc_a <= cnt >= Q && cnt < 3 * Q;
        // Single channel parts leave B low, so no stray edges appear
        enc_b <= dual && cnt >= 2 * Q;
    end
endmodule

/* sim/esm_asserts.sv */
// Bus checker for the encoder speed block
`timescale 1ns/1ns
`include "esm_map.vh"
module esm_asserts (
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // AXI4-Lite
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire ar_go  = s_axi_arvalid && s_axi_arready;
    wire w_go   = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                  && s_axi_wready;
    wire ar_bad = s_axi_araddr > 8'h1C || s_axi_araddr[1:0] != 2'b00;
    wire aw_ro  = s_axi_awaddr >= 8'h10 && s_axi_awaddr <= 8'h18;
    property p_ar_rdy; s_axi_arready == !s_axi_rvalid; endproperty
    a_ar_rdy: assert property (p_ar_rdy) else $error("arready wrong");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read dropped");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write resp dropped");
    property p_r_ans; ar_go |=> s_axi_rvalid; endproperty
    a_r_ans: assert property (p_r_ans) else $error("read late");
    property p_b_blk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_blk: assert property (p_b_blk) else $error("write taken early");
    property p_b_ans; w_go |-> ##[1:2] s_axi_bvalid; endproperty
    a_b_ans: assert property (p_b_ans) else $error("write resp late");
    property p_r_bad; ar_go && ar_bad |=> s_axi_rdata == 32'h0000_0000
        && s_axi_rresp == `ESM_RESP_SLVERR; endproperty
    a_r_bad: assert property (p_r_bad) else $error("bad read accepted");
    property p_ro_wr; w_go && aw_ro |-> ##[1:2] s_axi_bvalid
        && s_axi_bresp == `ESM_RESP_SLVERR; endproperty
    a_ro_wr: assert property (p_ro_wr) else $error("ro write ok");
    c_wr: cover property (w_go);
    c_bad: cover property (ar_go && ar_bad);
    c_ro: cover property (w_go && aw_ro);
endmodule
bind esm_top esm_asserts i_chk (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

/* sim/esm_top_tb.sv */
// Self-checking bench for the encoder speed block
`timescale 1ns/1ns
`include "esm_map.vh"
module esm_top_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    wire         s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'b0;
    wire         s_axi_wready;
    wire  [1:0]  s_axi_bresp;
    wire         s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    wire         s_axi_arready;
    wire  [31:0] s_axi_rdata;
    wire  [1:0]  s_axi_rresp;
    wire         s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    wire         enc_a;
    wire         enc_b;
    logic        enc_on = 1'b0;
    logic        enc_dual = 1'b0;
    integer      n_fail = 0;
    integer      samples_checked = 0;
    logic [31:0] rd;
    logic [1:0]  rs;
    esm_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .enc_a, .enc_b);
    esm_enc_model i_enc (.aclk, .run(enc_on), .dual(enc_dual), .enc_a,
        .enc_b);
    task automatic check(input string nm, input [31:0] seen,
                         input [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Leading edge keeps a release and a new request apart
    task automatic wr(input [7:0] a, input [31:0] d, output [1:0] r);
        integer n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 50) n_fail++;
    endtask
    task automatic rd_reg(input [7:0] a, output [31:0] d, output [1:0] r);
        integer n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) n_fail++;
    endtask
    task automatic rchk(input string nm, input [7:0] a, input [31:0] e);
        rd_reg(a, rd, rs);
        check(nm, rd, e);
    endtask
    task automatic t_reset;
        logic [31:0] rv [8] = '{32'h0000_0000, 32'h0000_0400,
            32'h0000_0001, 32'h0000_61A8, 32'h0000_0000, 32'h0000_0000,
            32'h0000_0000, 32'h0000_0002};
        for (int i = 0; i < 8; i++) rchk("reset value", 8'(i * 4), rv[i]);
    endtask
    task automatic t_err;
        rd_reg(8'h20, rd, rs);
        check("bad read resp", rs, `ESM_RESP_SLVERR);
        check("bad read data", rd, 32'h0000_0000);
        wr(8'h10, 32'h0000_1234, rs);
        check("ro write resp", rs, `ESM_RESP_SLVERR);
        wr(8'h24, 32'h0000_0001, rs);
        check("bad write resp", rs, `ESM_RESP_SLVERR);
        rchk("count after write", 8'h10, 32'h0000_0000);
        wr(8'h1C, 32'h0000_0003, rs);
        check("poles write resp", rs, `ESM_RESP_OKAY);
        rchk("poles readback", 8'h1C, 32'h0000_0003);
        // Only byte lane 1 may land, lane 0 keeps its old value
        s_axi_wstrb <= 4'h2;
        wr(8'h08, 32'h0000_0505, rs);
        s_axi_wstrb <= 4'hF;
        rchk("mult lanes", 8'h08, 32'h0000_0501);
        wr(8'h08, 32'h0000_0001, rs);
        wr(8'h1C, 32'h0000_0002, rs);
        rchk("poles restored", 8'h1C, 32'h0000_0002);
    endtask
    // Ten A pulses fall in each 5000 cycle period, period count kept low
    task automatic t_single;
        wr(8'h04, 32'h0000_000A, rs);
        wr(8'h0C, 32'h0000_1388, rs);
        check("cfg write resp", rs, `ESM_RESP_OKAY);
        enc_on <= 1'b1;
        repeat (6000) @(posedge aclk);
        rchk("count disabled", 8'h10, 32'h0000_0000);
        wr(8'h00, 32'h0000_0001, rs);
        repeat (11000) @(posedge aclk);
        rchk("single count", 8'h10, 32'h0000_000A);
        rchk("single freq", 8'h14, 32'h0027_1000);
        rchk("status", 8'h18, 32'h0000_0001);
    endtask
    task automatic t_dual;
        wr(8'h08, 32'h0000_0002, rs);
        wr(8'h00, 32'h0000_0003, rs);
        enc_dual <= 1'b1;
        repeat (11000) @(posedge aclk);
        rchk("dual count", 8'h10, 32'h0000_0028);
        rchk("dual freq", 8'h14, 32'h0013_8800);
        wr(8'h00, 32'h0000_0000, rs);
        rchk("count cleared", 8'h10, 32'h0000_0000);
        rchk("freq cleared", 8'h14, 32'h0000_0000);
    endtask
    initial begin
        forever #20 aclk = ~aclk;
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_err;
        t_single;
        t_dual;
        complete_run;
    end
    initial begin
        repeat (40000) @(posedge aclk);
        n_fail++;
        complete_run;
    end
endmodule
